// >>> pm_host_model.sv
// host processor model: turns bench requests into access strobes of the same length
// assumes the bench raises and drops each request at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module pm_host_model (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic strict_i,
    input wire logic req_read_i,
    input wire logic req_ctrl_i,
    input wire logic req_wake_i,
    input wire logic ready_i,
    output logic host_read_o,
    output logic ctrl_write_o,
    output logic wake_write_o
);
    // ****************************************
    // access discipline
    // ****************************************
    logic read_seen;

    // a lax host skips its own checks, only when a refusal is being tested
    assign host_read_o = req_read_i;
    assign ctrl_write_o = req_ctrl_i & (~strict_i | (ready_i & read_seen));
    assign wake_write_o = req_wake_i;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i || wake_write_o) begin
            read_seen <= 1'b0;
        end else if (host_read_o && ready_i) begin
            read_seen <= 1'b1;
        end
    end
endmodule : pm_host_model
`default_nettype wire

// >>> pm_pulse_timer.sv
// one-shot timer: active for LENGTH cycles after a start pulse
// assumes start is a single-cycle pulse on the core clock
`timescale 1ns/100ps
`default_nettype none
module pm_pulse_timer #(
    parameter int unsigned LENGTH = 16
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic active_o
);
    import pm_wake_pkg::*;

    localparam int unsigned CW = $clog2(LENGTH + 1);

    initial begin
        if (LENGTH < 1) begin
            $error("pulse length must be at least one cycle");
        end
    end

    typedef struct packed {
        logic [CW-1:0] left;
    } tmr_t;

    tmr_t cur;
    tmr_t next_cur;

    always_comb begin
        next_cur = cur;
        if (abort_i) begin
            next_cur.left = '0;
        end else if (start_i) begin
            next_cur.left = CW'(LENGTH);
        end else if (cur.left != '0) begin
            next_cur.left = cur.left - CW'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cur <= '0;
        end else if (ce_i) begin
            cur <= next_cur;
        end
    end

    assign active_o = (cur.left != '0);

endmodule : pm_pulse_timer
`default_nettype wire

// >>> pm_sync2.sv
// two-flop synchroniser for a single level from outside the core clock domain
// assumes the level is slow compared with the clock
`timescale 1ns/100ps
`default_nettype none
module pm_sync2 (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic async_i,
    output logic sync_o
);
    import pm_wake_pkg::*;

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_t;

    sync_t cur;
    sync_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.meta = async_i;
        next_cur.stable = cur.meta;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cur <= '0;
        end else if (ce_i) begin
            cur <= next_cur;
        end
    end

    assign sync_o = cur.stable;

endmodule : pm_sync2
`default_nettype wire

// >>> pm_wake_pkg.sv
// power-state and wake control package: encodings, reset values, timing constants
// assumes a 100 MHz core clock for every cycle count below
package pm_wake_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned READY_MAX_NS = 2_000_000;
    localparam int unsigned READY_MAX_CYCLES = READY_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned PIN_PULSE_NS = 50_000_000;
    localparam int unsigned PIN_PULSE_CYCLES = PIN_PULSE_NS / CLK_PERIOD_NS;

    // ****************************************
    // field encodings and reset values
    // ****************************************
    localparam logic [1:0] PSF_NORMAL = 2'h0;
    localparam logic [1:0] PSF_WAKE_FRAME = 2'h1;
    localparam logic [1:0] PSF_ENERGY = 2'h2;
    localparam logic [1:0] WSF_NONE = 2'h0;
    localparam logic [1:0] WSF_ENERGY = 2'h1;
    localparam logic [1:0] WSF_WAKE_FRAME = 2'h2;
    localparam logic [1:0] PSF_RESET = PSF_NORMAL;
    localparam logic [1:0] WSF_RESET = WSF_NONE;
    localparam int unsigned WSF_ENERGY_BIT = 0;
    localparam int unsigned WSF_FRAME_BIT = 1;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_WAKE_FRAME_SLEEP,
        ST_ENERGY_SLEEP,
        ST_RESUME
    } pm_state_t;

endpackage : pm_wake_pkg

// >>> power_state_wake_control.sv
// power-state and wake controller: sleep states, clock gating, wake pin and wake status
// assumes host access strobes and wake-frame detect come from logic on mclk_i;
// the line energy level comes from the analog front end and is synchronised here
`timescale 1ns/100ps
`default_nettype none
module power_state_wake_control #(
    parameter int unsigned READY_DELAY = pm_wake_pkg::READY_MAX_CYCLES,
    parameter int unsigned PIN_PULSE = pm_wake_pkg::PIN_PULSE_CYCLES
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic host_read_i,
    input wire logic wake_write_i,
    input wire logic ctrl_write_i,
    input wire logic [1:0] wr_power_state_field_i,
    input wire logic wr_wake_frame_enable_i,
    input wire logic wr_energy_wake_enable_i,
    input wire logic wr_pin_enable_i,
    input wire logic wr_wake_pin_pulse_select_i,
    input wire logic [1:0] wr_wake_status_clear_i,
    input wire logic int_status_clear_i,
    input wire logic wake_frame_detect_i,
    input wire logic energy_present_i,
    input wire logic phy_general_powerdown_i,
    input wire logic energy_detect_powerdown_bit_i,
    input wire logic phy_flag_clear_i,
    input wire logic phy_int_enable_i,
    input wire logic wake_int_enable_i,
    output logic [1:0] power_state_field_o,
    output logic ready_o,
    output logic [1:0] wake_status_field_o,
    output logic wake_frame_enable_o,
    output logic energy_wake_enable_o,
    output logic pin_enable_o,
    output logic wake_pin_pulse_select_o,
    output logic wake_int_status_o,
    output logic host_irq_o,
    output logic wake_pin_o,
    output logic mac_clk_en_o,
    output logic mac_rx_pm_clk_en_o,
    output logic host_if_clk_en_o,
    output logic internal_clk_en_o,
    output logic phy_clk_en_o,
    output logic phy_core_power_o,
    output logic phy_tx_enable_o,
    output logic phy_auto_reset_o,
    output logic phy_energy_flag_o,
    output logic phy_irq_o
);
    import pm_wake_pkg::*;

    localparam int unsigned CW = $clog2(READY_DELAY + 1);

    initial begin
        if (READY_DELAY < 1 || READY_DELAY > READY_MAX_CYCLES) begin
            $error("ready delay must be 1 to the 2 ms cycle count");
        end
        if (PIN_PULSE < 1) begin
            $error("pin pulse must be at least one cycle");
        end
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pm_state_t st;
        logic [1:0] wake_status;
        logic wf_en;
        logic energy_wake_enable;
        logic pin_en;
        logic pulse_sel;
        logic ready;
        logic read_seen;
        logic wake_int;
        logic pin_cond_d;
        logic gen_pd_d;
        logic energy_d;
        logic phy_flag;
        logic phy_reset;
        logic [CW-1:0] resume_cnt;
    } ctl_t;

    ctl_t cur;
    ctl_t next_cur;
    logic energy_sync;
    logic wake_irq_src;
    logic pin_cond;
    logic pin_rise;
    logic pulse_active;
    logic write_ok;

    pm_sync2 u_energy_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .async_i(energy_present_i),
        .sync_o(energy_sync)
    );

    // internal wake interrupt: a status bit with its matching enable
    assign wake_irq_src = (cur.wake_status[WSF_FRAME_BIT] & cur.wf_en) |
                          (cur.wake_status[WSF_ENERGY_BIT] & cur.energy_wake_enable);
    assign pin_cond = wake_irq_src & cur.pin_en;
    assign pin_rise = pin_cond & ~cur.pin_cond_d;
    // host writes other than the wake write are ignored until ready and a first read
    assign write_ok = ctrl_write_i & cur.ready & cur.read_seen;

    pm_pulse_timer #(
        .LENGTH(PIN_PULSE)
    ) u_pin_pulse (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .start_i(pin_rise),
        .abort_i(~pin_cond),
        .active_o(pulse_active)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        next_cur = cur;
        next_cur.pin_cond_d = pin_cond;
        next_cur.gen_pd_d = phy_general_powerdown_i;
        next_cur.energy_d = energy_sync;
        next_cur.phy_reset = 1'b0;
        if (host_read_i) begin
            next_cur.read_seen = 1'b1;
        end
        // control fields written only in normal state; otherwise all hold but wake status, which the sleep states set on detect
        if (write_ok) begin
            next_cur.wf_en = wr_wake_frame_enable_i;
            next_cur.energy_wake_enable = wr_energy_wake_enable_i;
            next_cur.pin_en = wr_pin_enable_i;
            next_cur.pulse_sel = wr_wake_pin_pulse_select_i;
            next_cur.wake_status = cur.wake_status & ~wr_wake_status_clear_i;
        end
        unique case (cur.st)
            ST_NORMAL: begin
                if (write_ok && wr_power_state_field_i == PSF_WAKE_FRAME) begin
                    next_cur.st = ST_WAKE_FRAME_SLEEP;
                    next_cur.ready = 1'b0;
                end else if (write_ok && wr_power_state_field_i == PSF_ENERGY &&
                             energy_detect_powerdown_bit_i) begin
                    next_cur.st = ST_ENERGY_SLEEP;
                    next_cur.ready = 1'b0;
                end
            end
            ST_WAKE_FRAME_SLEEP: begin
                if (wake_frame_detect_i) begin
                    next_cur.wake_status = WSF_WAKE_FRAME;
                end
            end
            ST_ENERGY_SLEEP: begin
                // level sensed, so a carrier present at entry reports at once
                if (energy_sync) begin
                    next_cur.wake_status = WSF_ENERGY;
                end
            end
            ST_RESUME: begin
                if (cur.resume_cnt == CW'(1)) begin
                    next_cur.st = ST_NORMAL;
                    next_cur.ready = 1'b1;
                end
                next_cur.resume_cnt = cur.resume_cnt - CW'(1);
            end
        endcase
        if (wake_write_i && (cur.st == ST_WAKE_FRAME_SLEEP || cur.st == ST_ENERGY_SLEEP)) begin
            next_cur.st = ST_RESUME;
            next_cur.resume_cnt = CW'(READY_DELAY);
            next_cur.read_seen = 1'b0;
        end
        // sticky status: set wins, write-one clear only once the source is gone
        if (wake_irq_src) begin
            next_cur.wake_int = 1'b1;
        end else if (int_status_clear_i && cur.read_seen) begin
            next_cur.wake_int = 1'b0;
        end
        // phy auto reset on general power-up, restore on energy return
        if (cur.gen_pd_d && !phy_general_powerdown_i) begin
            next_cur.phy_reset = 1'b1;
        end
        if (energy_detect_powerdown_bit_i && energy_sync && !cur.energy_d) begin
            next_cur.phy_reset = 1'b1;
            next_cur.phy_flag = 1'b1;
        end else if (phy_flag_clear_i) begin
            next_cur.phy_flag = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cur <= '0;
            cur.st <= ST_NORMAL;
            cur.wake_status <= WSF_RESET;
            cur.ready <= 1'b1;
        end else if (ce_i) begin
            cur <= next_cur;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        unique case (cur.st)
            ST_NORMAL: power_state_field_o = PSF_NORMAL;
            ST_WAKE_FRAME_SLEEP: power_state_field_o = PSF_WAKE_FRAME;
            ST_ENERGY_SLEEP: power_state_field_o = PSF_ENERGY;
            ST_RESUME: power_state_field_o = PSF_NORMAL;
        endcase
    end

    assign ready_o = cur.ready;
    assign wake_status_field_o = cur.wake_status;
    assign wake_frame_enable_o = cur.wf_en;
    assign energy_wake_enable_o = cur.energy_wake_enable;
    assign pin_enable_o = cur.pin_en;
    assign wake_pin_pulse_select_o = cur.pulse_sel;
    assign wake_int_status_o = cur.wake_int;
    assign host_irq_o = cur.wake_int & wake_int_enable_i;
    assign wake_pin_o = cur.pulse_sel ? (pin_cond & pulse_active) : pin_cond;
    // clock gating follows the power state
    assign mac_clk_en_o = (cur.st == ST_NORMAL) || (cur.st == ST_RESUME);
    assign host_if_clk_en_o = (cur.st == ST_NORMAL) || (cur.st == ST_RESUME);
    assign mac_rx_pm_clk_en_o = (cur.st != ST_ENERGY_SLEEP);
    assign internal_clk_en_o = (cur.st != ST_ENERGY_SLEEP);
    assign phy_clk_en_o = (cur.st != ST_ENERGY_SLEEP);
    // only the management, squelch and energy logic stay up while powered down
    assign phy_core_power_o = ~cur.gen_pd_d & ~(energy_detect_powerdown_bit_i & ~energy_sync);
    assign phy_tx_enable_o = phy_core_power_o;
    assign phy_auto_reset_o = cur.phy_reset;
    assign phy_energy_flag_o = cur.phy_flag;
    assign phy_irq_o = cur.phy_flag & phy_int_enable_i;

    // ****************************************
    // assertions
    // ****************************************
    a_sleep_clears_ready: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cur.st != ST_NORMAL) |-> !ready_o)
        else $error("ready high outside normal state");

    a_wake_to_resume: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (ce_i && wake_write_i && (cur.st == ST_WAKE_FRAME_SLEEP || cur.st == ST_ENERGY_SLEEP))
        |=> (cur.st == ST_RESUME) && (power_state_field_o == PSF_NORMAL))
        else $error("wake write did not start resume");

    a_resume_count_bound: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cur.st == ST_RESUME) |-> (cur.resume_cnt <= CW'(READY_DELAY)) && (cur.resume_cnt != '0))
        else $error("resume counter out of range");

    a_frame_status: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (ce_i && cur.st == ST_WAKE_FRAME_SLEEP && wake_frame_detect_i && !wake_write_i)
        |=> (wake_status_field_o == WSF_WAKE_FRAME))
        else $error("frame detect did not set status");

    a_energy_status: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (ce_i && cur.st == ST_ENERGY_SLEEP && energy_sync && !wake_write_i)
        |=> (wake_status_field_o == WSF_ENERGY))
        else $error("energy detect did not set status");

    a_int_sticky: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (ce_i && wake_irq_src) |=> wake_int_status_o)
        else $error("wake interrupt status not set");

    a_pin_needs_enable: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wake_pin_o |-> cur.pin_en && wake_irq_src)
        else $error("wake pin active without enables");

    a_pin_steady: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (pin_cond && !cur.pulse_sel) |-> wake_pin_o)
        else $error("static wake pin not driven");

    a_energy_clocks_off: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cur.st == ST_ENERGY_SLEEP) |-> !(mac_clk_en_o || host_if_clk_en_o || internal_clk_en_o))
        else $error("clocks running in energy sleep");

    a_write_gated: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (ce_i && ctrl_write_i && !cur.read_seen && !wake_write_i) |=> $stable(cur.wf_en))
        else $error("write took effect before first read");

endmodule : power_state_wake_control
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the power-state and wake controller
// assumes short ready and pin-pulse counts set through the parameters
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pm_wake_pkg::*;
    localparam int unsigned RDY = 5;
    localparam int unsigned PULSE = 8;
    localparam int LIMIT = 2000;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic strict = 1'b1, rq_rd = 1'b0, rq_ctl = 1'b0, rq_wk = 1'b0;
    logic host_read, wake_write, ctrl_write;
    logic [1:0] wr_psf = 2'h0, wr_wsc = 2'h0;
    logic wr_wf = 1'b0, wr_ed = 1'b0, wr_pin = 1'b0, wr_pls = 1'b0;
    logic int_clr = 1'b0, wf_det = 1'b0, energy = 1'b0, gpd = 1'b0, edpd = 1'b0, flag_clr = 1'b0;
    logic phy_ie = 1'b1, wake_ie = 1'b1;
    logic [1:0] psf, wsf;
    logic ready, wf_en, energy_wake_enable, pin_en, pls_sel, interrupt_status_reg, host_irq, pin;
    logic mac_ce, rxpm_ce, hif_ce, int_ce, phy_ce, phy_pwr, phy_tx, phy_rst, phy_flag, phy_irq;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    // gpd, edpd, energy, expected phy power
    logic [3:0] rows [8] = '{4'h1, 4'h3, 4'h7, 4'h4, 4'hC, 4'h8, 4'hA, 4'hE};

    always #5 mclk_i = ~mclk_i;

    power_state_wake_control #(.READY_DELAY(RDY), .PIN_PULSE(PULSE)) power_state_wake_control_i (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .host_read_i(host_read),
        .wake_write_i(wake_write), .ctrl_write_i(ctrl_write), .wr_power_state_field_i(wr_psf),
        .wr_wake_frame_enable_i(wr_wf), .wr_energy_wake_enable_i(wr_ed), .wr_pin_enable_i(wr_pin),
        .wr_wake_pin_pulse_select_i(wr_pls), .wr_wake_status_clear_i(wr_wsc),
        .int_status_clear_i(int_clr), .wake_frame_detect_i(wf_det), .energy_present_i(energy),
        .phy_general_powerdown_i(gpd), .energy_detect_powerdown_bit_i(edpd),
        .phy_flag_clear_i(flag_clr), .phy_int_enable_i(phy_ie), .wake_int_enable_i(wake_ie),
        .power_state_field_o(psf), .ready_o(ready), .wake_status_field_o(wsf),
        .wake_frame_enable_o(wf_en), .energy_wake_enable_o(energy_wake_enable), .pin_enable_o(pin_en),
        .wake_pin_pulse_select_o(pls_sel), .wake_int_status_o(interrupt_status_reg), .host_irq_o(host_irq),
        .wake_pin_o(pin), .mac_clk_en_o(mac_ce), .mac_rx_pm_clk_en_o(rxpm_ce),
        .host_if_clk_en_o(hif_ce), .internal_clk_en_o(int_ce), .phy_clk_en_o(phy_ce),
        .phy_core_power_o(phy_pwr), .phy_tx_enable_o(phy_tx), .phy_auto_reset_o(phy_rst),
        .phy_energy_flag_o(phy_flag), .phy_irq_o(phy_irq));

    pm_host_model pm_host_model_i (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .strict_i(strict), .req_read_i(rq_rd),
        .req_ctrl_i(rq_ctl), .req_wake_i(rq_wk), .ready_i(ready), .host_read_o(host_read),
        .ctrl_write_o(ctrl_write), .wake_write_o(wake_write));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc

    // op 1 read, 2 control write, 3 wake write; one cycle each
    task automatic host(input logic [1:0] op);
        @(negedge mclk_i);
        rq_rd = (op == 2'h1);
        rq_ctl = (op == 2'h2);
        rq_wk = (op == 2'h3);
        @(negedge mclk_i);
        rq_rd = 1'b0;
        rq_ctl = 1'b0;
        rq_wk = 1'b0;
    endtask : host

    task automatic ctl(input logic [1:0] ps, input logic wf, ed, pe, pl, input logic [1:0] wc);
        wr_psf = ps;
        wr_wf = wf;
        wr_ed = ed;
        wr_pin = pe;
        wr_pls = pl;
        wr_wsc = wc;
        host(2'h2);
    endtask : ctl

    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1 && n < RDY + 4) begin
            @(negedge mclk_i);
            n++;
        end
        check("ready after wake", ready, 1'b1);
    endtask : wait_ready

    task automatic pulse_int_clear;
        @(negedge mclk_i);
        int_clr = 1'b1;
        @(negedge mclk_i);
        int_clr = 1'b0;
        cyc(2);
    endtask : pulse_int_clear

    // ****************************************
    // timeout
    // ****************************************
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        cyc(10);
        nrst_i = 1'b1;
        cyc(1);
        check("power state", psf, PSF_RESET);
        check("wake status", wsf, WSF_RESET);
        check("ready", ready, 1'b1);
        check("clocks", {mac_ce, int_ce}, 2'h3);
        for (int k = 0; k < 8; k++) begin
            {gpd, edpd, energy} = rows[k][3:1];
            cyc(4);
            check("phy power", phy_pwr, rows[k][0]);
            check("phy tx", phy_tx, rows[k][0]);
        end
        gpd = 1'b0;
        for (int i = 0; i < 4 && phy_rst !== 1'b1; i++) @(negedge mclk_i);
        check("phy auto reset", phy_rst, 1'b1);
        energy = 1'b0;
        cyc(4);
        energy = 1'b1;
        for (int i = 0; i < 6 && phy_flag !== 1'b1; i++) @(negedge mclk_i);
        check("phy flag", {phy_flag, phy_irq, phy_rst}, 3'h7);
        phy_ie = 1'b0;
        cyc(1);
        check("phy irq masked", {phy_flag, phy_irq}, 2'h2);
        phy_ie = 1'b1;
        flag_clr = 1'b1;
        cyc(1);
        flag_clr = 1'b0;
        check("phy flag cleared", phy_flag, 1'b0);
        edpd = 1'b0;
        // writes before the first read are dropped
        strict = 1'b0;
        ctl(PSF_WAKE_FRAME, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
        cyc(2);
        check("write before read", {psf, wf_en}, {PSF_NORMAL, 1'b0});
        strict = 1'b1;
        host(2'h1);
        ctl(PSF_ENERGY, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
        cyc(2);
        check("energy sleep without powerdown", psf, PSF_NORMAL);
        check("written fields", {energy_wake_enable, pin_en, pls_sel}, 3'h6);
        ctl(PSF_WAKE_FRAME, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
        cyc(1);
        check("frame sleep entry", psf, PSF_WAKE_FRAME);
        check("ready in sleep", ready, 1'b0);
        check("stopped clocks", {mac_ce, hif_ce}, 2'h0);
        check("running clocks", {rxpm_ce, phy_ce}, 2'h3);
        strict = 1'b0;
        ctl(PSF_NORMAL, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
        cyc(2);
        check("write while asleep", {psf, wf_en}, {PSF_WAKE_FRAME, 1'b1});
        strict = 1'b1;
        wf_det = 1'b1;
        cyc(1);
        wf_det = 1'b0;
        cyc(3);
        check("frame wake status", wsf, WSF_WAKE_FRAME);
        check("irq status", {interrupt_status_reg, host_irq}, 2'h3);
        wake_ie = 1'b0;
        cyc(PULSE + 4);
        check("steady pin", {pin, interrupt_status_reg, host_irq}, 3'h6);
        wake_ie = 1'b1;
        host(2'h3);
        cyc(1);
        check("wake write", {psf, ready}, {PSF_NORMAL, 1'b0});
        wait_ready();
        check("status kept", {wsf, wf_en}, {WSF_WAKE_FRAME, 1'b1});
        host(2'h1);
        pulse_int_clear();
        check("sticky status", interrupt_status_reg, 1'b1);
        ctl(PSF_NORMAL, 1'b1, 1'b0, 1'b1, 1'b0, 2'h2);
        cyc(2);
        check("status cleared", {wsf, pin}, {WSF_NONE, 1'b0});
        pulse_int_clear();
        check("irq status cleared", interrupt_status_reg, 1'b0);
        // carrier already on the line when energy sleep starts
        edpd = 1'b1;
        ctl(PSF_ENERGY, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
        cyc(4);
        check("energy sleep entry", {psf, ready}, {PSF_ENERGY, 1'b0});
        check("energy wake status", wsf, WSF_ENERGY);
        check("status without pin", {interrupt_status_reg, pin}, 2'h2);
        check("energy sleep clocks", {mac_ce, hif_ce}, 2'h0);
        check("energy sleep clocks", {int_ce, phy_ce}, 2'h0);
        host(2'h3);
        wait_ready();
        edpd = 1'b0;
        host(2'h1);
        ctl(PSF_NORMAL, 1'b0, 1'b1, 1'b1, 1'b0, 2'h1);
        pulse_int_clear();
        check("energy status cleared", {wsf, interrupt_status_reg}, 3'h0);
        ctl(PSF_WAKE_FRAME, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0);
        wf_det = 1'b1;
        cyc(1);
        wf_det = 1'b0;
        cyc(2);
        check("pulse pin on", pin, 1'b1);
        check("pulse fields", {wf_en, energy_wake_enable, pin_en, pls_sel}, 4'hB);
        cyc(PULSE + 2);
        check("pulse pin off", {wsf, pin}, {WSF_WAKE_FRAME, 1'b0});
        ce_i = 1'b0;
        host(2'h3);
        cyc(1);
        check("frozen by clock enable", {psf, ready}, {PSF_WAKE_FRAME, 1'b0});
        nrst_i = 1'b0;
        cyc(2);
        nrst_i = 1'b1;
        ce_i = 1'b1;
        cyc(1);
        check("reset in sleep", {psf, wsf}, {PSF_RESET, WSF_RESET});
        check("reset ready", {ready, pin}, 2'h2);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
